// ===== logic/stp_cfg_regs.sv
// Configuration register array of the stepper terminal
`timescale 1ns/1ps
module stp_cfg_regs (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic wr_en_in,
	input wire logic [stp_pkg::REGNO_W-1:0] addr_in,
	input wire logic [stp_pkg::DATA_W-1:0] wdata_in,
	output logic [stp_pkg::DATA_W-1:0] rdata_out,
	output logic [stp_pkg::DATA_W-1:0] reduced_current_out,
	output logic [stp_pkg::DATA_W-1:0] angle_threshold_out,
	output logic [stp_pkg::DATA_W-1:0] emerg_decel_out
);
	import stp_pkg::*;

	typedef struct packed {
		logic [REG_COUNT-1:0][DATA_W-1:0] mem;
		logic [DATA_W-1:0] rdata;
	} stp_cfg_s;

	stp_cfg_s cur;
	stp_cfg_s next_cur;

	// Read first, read returns the old word
	always_comb begin
		next_cur = cur;
		if (wr_en_in) begin
			next_cur.mem[addr_in] = wdata_in;
		end
		next_cur.rdata = cur.mem[addr_in];
	end

	// Whole array resets to one value
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur <= {(REG_COUNT + 1){CFG_RST}};
		end else if (clk_en_in) begin
			cur <= next_cur;
		end
	end

	// Taps feeding the motor core
	assign rdata_out = cur.rdata;
	assign reduced_current_out = cur.mem[REG_REDCUR];
	assign angle_threshold_out = cur.mem[REG_ANGLE_THR];
	assign emerg_decel_out = cur.mem[REG_EDECEL];

	property p_cfg_write;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && wr_en_in && addr_in == REG_REDCUR
		|=> reduced_current_out == $past(wdata_in);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("reduced current word not written");

endmodule

// ===== logic/stp_pkg.sv
// Shared constants and types of the stepper control/status byte block
package stp_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int BYTE_W = 8;
	localparam int DATA_W = 16;
	localparam int REGNO_W = 6;
	localparam int ANGLE_W = 3;
	localparam int MODE_W = 2;
	localparam int TEMP_W = 8;
	localparam int REG_COUNT = 64;

	// ****************************************
	// Control byte fields
	// ****************************************
	localparam int CB_ENABLE = 0;
	localparam int CB_EHALT = 1;
	localparam int CB_START = 2;
	localparam int CB_REDCUR = 3;
	localparam int CB_ALAUNCH = 4;
	localparam int CB_AHALT = 5;
	localparam int CB_ERRCLR = 6;
	localparam int CB_RW = 6;
	localparam int CB_REGSEL = 7;

	// ****************************************
	// Status byte fields
	// ****************************************
	localparam int SB_READY = 0;
	localparam int SB_ANGLE_LO = 1;
	localparam int SB_IDLE = 4;
	localparam int SB_WARN = 5;
	localparam int SB_ERROR = 6;
	localparam int SB_REGACK = 7;

	// ****************************************
	// Configuration register numbers
	// ****************************************
	localparam logic [5:0] REG_REDCUR = 6'h2D;    // 45
	localparam logic [5:0] REG_ANGLE_THR = 6'h2F; // 47
	localparam logic [5:0] REG_EDECEL = 6'h32;    // 50

	// Warning temperature in degrees Celsius
	localparam logic [7:0] TEMP_WARN_C = 8'h50;   // 80

	// ****************************************
	// Operating modes
	// ****************************************
	localparam logic [1:0] MODE_VEL_DIRECT = 2'h0;
	localparam logic [1:0] MODE_VEL_RAMP = 2'h1;
	localparam logic [1:0] MODE_POS_TRACK = 2'h2;
	localparam logic [1:0] MODE_PATH = 2'h3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h0000;

	// Byte exchange sequencer
	typedef enum logic [2:0] {
		ST_PROC = 3'b001,
		ST_ACC = 3'b010,
		ST_ACK = 3'b100
	} stp_state_e;

endpackage

// ===== logic/stp_status_byte.sv
// Control byte decoder and status byte builder of the stepper terminal
//
// Notes on behaviour
// - Control bit 7 low selects process data mode; other bits are commands.
// - In process data mode status bit 7 reads zero.
// - Rising edge of control bit 6 clears every latched error.
// - Control bit 5 enables auto stop, except in position tracking.
// - Control bit 4 enables auto start, only in path control.
// - Control bit 3 applies reduced standstill current from register 45.
// - In path control, control bit 2 starts or stops the motion command.
// - In path control, bit 1 rising edge halts with register 50 deceleration.
// - Bit 0 enables control; status bit 0 is enable and no error.
// - Status bit 6 is one while an error is present.
// - Status bit 5 warns above 80 C or load angle over register 47.
// - Status bit 4 is one when no instruction is in progress.
// - Status bits 3 to 1 carry the three-bit load angle.
// - Terminal acknowledges a register access with status bit 7 high.
// - Status bits 5 to 0 echo the register number accessed.
// - Control and status bytes are always present in the image.
`timescale 1ns/1ps
module stp_status_byte (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic [stp_pkg::BYTE_W-1:0] motion_control_byte_in,
	input wire logic [stp_pkg::DATA_W-1:0] output_data_word_in,
	input wire logic [stp_pkg::MODE_W-1:0] operating_mode_in,
	input wire logic error_event_in,
	input wire logic motor_running_in,
	input wire logic [stp_pkg::TEMP_W-1:0] die_temperature_in,
	input wire logic [stp_pkg::ANGLE_W-1:0] load_angle_field_in,
	input wire logic [stp_pkg::DATA_W-1:0] actual_position_in,
	output logic [stp_pkg::BYTE_W-1:0] terminal_status_byte_out,
	output logic [stp_pkg::DATA_W-1:0] input_data_word_out,
	output logic motor_enable_out,
	output logic reduced_current_out,
	output logic automatic_halt_enable_out,
	output logic automatic_launch_enable_out,
	output logic motion_start_out,
	output logic emergency_halt_request_out,
	output logic errors_cleared_out,
	output logic [stp_pkg::DATA_W-1:0] reduced_current_setting_out,
	output logic [stp_pkg::DATA_W-1:0] emergency_deceleration_setting_out
);
	import stp_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************

	// Path control gates start, launch and halt
	function automatic logic is_path(input logic [MODE_W-1:0] m);
		is_path = (m == MODE_PATH);
	endfunction

	// Auto stop is meaningless while tracking a set position
	function automatic logic is_track(input logic [MODE_W-1:0] m);
		is_track = (m == MODE_POS_TRACK);
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		stp_state_e st;
		logic [BYTE_W-1:0] ctrl_q;
		logic err;
		logic en;
		logic red;
		logic ahalt;
		logic alaunch;
		logic start;
		logic ehalt;
		logic clr;
		logic rw;
		logic [REGNO_W-1:0] regno;
		logic [BYTE_W-1:0] status;
		logic [DATA_W-1:0] data;
	} stp_top_s;

	stp_top_s cur;
	stp_top_s next_cur;

	logic proc_mode;
	logic path_mode;
	logic clr_edge;
	logic halt_edge;
	logic warn;
	logic cfg_wr;
	logic new_req;
	logic [DATA_W-1:0] cfg_rdata;
	logic [DATA_W-1:0] angle_thr;
	logic [DATA_W-1:0] angle_wide;

	// ****************************************
	// Configuration registers
	// ****************************************
	stp_cfg_regs u_cfg (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.wr_en_in(cfg_wr),
		.addr_in(cur.regno),
		.wdata_in(output_data_word_in),
		.rdata_out(cfg_rdata),
		.reduced_current_out(reduced_current_setting_out),
		.angle_threshold_out(angle_thr),
		.emerg_decel_out(emergency_deceleration_setting_out)
	);

	// Decoded views of the incoming control byte
	assign proc_mode = !motion_control_byte_in[CB_REGSEL];
	assign path_mode = is_path(operating_mode_in);
	assign clr_edge = motion_control_byte_in[CB_ERRCLR]
		&& !cur.ctrl_q[CB_ERRCLR];
	assign halt_edge = motion_control_byte_in[CB_EHALT]
		&& !cur.ctrl_q[CB_EHALT];
	assign new_req = motion_control_byte_in[CB_RW:0]
		!= {cur.rw, cur.regno};

	// Load angle widened to compare against a full register word
	assign angle_wide = {{(DATA_W - ANGLE_W){1'b0}}, load_angle_field_in};

	// Warning from either heat or mechanical load
	assign warn = (die_temperature_in > TEMP_WARN_C)
		|| (angle_wide > angle_thr);

	// ****************************************
	// Next state
	// ****************************************

	// Sequencer, command decode and status assembly
	always_comb begin
		next_cur = cur;
		cfg_wr = 1'b0;
		next_cur.ehalt = 1'b0;
		next_cur.clr = 1'b0;

		// Register access handshake
		unique case (cur.st)
			ST_PROC: begin
				if (!proc_mode) begin
					next_cur.st = ST_ACC;
					next_cur.rw = motion_control_byte_in[CB_RW];
					next_cur.regno = motion_control_byte_in[REGNO_W-1:0];
				end
			end
			ST_ACC: begin
				cfg_wr = cur.rw;
				next_cur.st = ST_ACK;
			end
			ST_ACK: begin
				if (proc_mode) begin
					next_cur.st = ST_PROC;
				end else if (new_req) begin
					// A changed request starts a fresh access
					next_cur.st = ST_ACC;
					next_cur.rw = motion_control_byte_in[CB_RW];
					next_cur.regno = motion_control_byte_in[REGNO_W-1:0];
				end
			end
			default: begin
				next_cur.st = ST_PROC;
			end
		endcase

		// Commands only mean something in process data layout;
		// in register layout the last level commands are held, the halt and clear pulses drop
		if (proc_mode) begin
			next_cur.ctrl_q = motion_control_byte_in;
			next_cur.en = motion_control_byte_in[CB_ENABLE];
			next_cur.red = motion_control_byte_in[CB_REDCUR];
			next_cur.ahalt = motion_control_byte_in[CB_AHALT]
				&& !is_track(operating_mode_in);
			next_cur.alaunch = motion_control_byte_in[CB_ALAUNCH]
				&& path_mode;
			next_cur.start = motion_control_byte_in[CB_START]
				&& path_mode;
			next_cur.ehalt = halt_edge && path_mode;
			next_cur.clr = clr_edge;
		end

		// New error wins over a clear in the same cycle
		next_cur.err = error_event_in
			|| (cur.err && !next_cur.clr);

		// Status and input word follow the active layout
		if (cur.st == ST_ACK) begin
			next_cur.status = {1'b1, cur.rw, cur.regno};
			next_cur.data = cfg_rdata;
		end else if (cur.st == ST_PROC) begin
			next_cur.status[SB_REGACK] = 1'b0;
			next_cur.status[SB_ERROR] = next_cur.err;
			next_cur.status[SB_WARN] = warn;
			next_cur.status[SB_IDLE] = !motor_running_in
				&& !next_cur.start;
			next_cur.status[SB_IDLE-1:SB_ANGLE_LO] =
				load_angle_field_in;
			next_cur.status[SB_READY] = next_cur.en
				&& !next_cur.err;
			next_cur.data = actual_position_in;
		end
	end

	// ****************************************
	// Registers
	// ****************************************

	// Clock enable freezes everything, including pulses
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur.st <= ST_PROC;
			cur.ctrl_q <= CTRL_RST;
			cur.err <= 1'b0;
			cur.en <= 1'b0;
			cur.red <= 1'b0;
			cur.ahalt <= 1'b0;
			cur.alaunch <= 1'b0;
			cur.start <= 1'b0;
			cur.ehalt <= 1'b0;
			cur.clr <= 1'b0;
			cur.rw <= 1'b0;
			cur.regno <= '0;
			cur.status <= STATUS_RST;
			cur.data <= DATA_RST;
		end else if (clk_en_in) begin
			cur <= next_cur;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	// Full image is always presented, never a compact one
	assign terminal_status_byte_out = cur.status;
	assign input_data_word_out = cur.data;
	assign motor_enable_out = cur.en;
	assign reduced_current_out = cur.red;
	assign automatic_halt_enable_out = cur.ahalt;
	assign automatic_launch_enable_out = cur.alaunch;
	assign motion_start_out = cur.start;
	assign emergency_halt_request_out = cur.ehalt;
	assign errors_cleared_out = cur.clr;

	// ****************************************
	// Checks
	// ****************************************

	// Helper views for the checks
	stp_state_e st_now;
	logic [REGNO_W-1:0] regno_q;
	assign st_now = cur.st;
	assign regno_q = cur.regno;

	sequence s_proc_cycle;
		clk_en_in && proc_mode && st_now == ST_PROC;
	endsequence

	sequence s_access;
		clk_en_in && st_now == ST_ACC ##1 clk_en_in;
	endsequence

	property p_pd_ack;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_proc_cycle |=> !terminal_status_byte_out[SB_REGACK];
	endproperty
	a_pd_ack: assert property (p_pd_ack)
		else $error("status bit 7 high in process data mode");

	property p_err_clear;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && proc_mode && clr_edge && !error_event_in
		|=> !cur.err ##0 errors_cleared_out;
	endproperty
	a_err_clear: assert property (p_err_clear)
		else $error("error not cleared on reset edge");

	property p_ready;
		@(posedge clk_in) disable iff (!rst_n_in)
		!terminal_status_byte_out[SB_REGACK]
		|-> terminal_status_byte_out[SB_READY] ==
		(motor_enable_out && !terminal_status_byte_out[SB_ERROR]);
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready bit disagrees with enable and error");

	property p_err_flag;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_proc_cycle and error_event_in
		|=> terminal_status_byte_out[SB_ERROR];
	endproperty
	a_err_flag: assert property (p_err_flag)
		else $error("error bit missing after error event");

	property p_warn;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_proc_cycle and die_temperature_in > TEMP_WARN_C
		|=> terminal_status_byte_out[SB_WARN];
	endproperty
	a_warn: assert property (p_warn)
		else $error("warning bit missing over temperature");

	property p_ehalt;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && proc_mode && path_mode && halt_edge
		|=> emergency_halt_request_out;
	endproperty
	a_ehalt: assert property (p_ehalt)
		else $error("emergency halt not requested on edge");

	property p_start;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && proc_mode
		|=> motion_start_out == $past(
		motion_control_byte_in[CB_START] && path_mode);
	endproperty
	a_start: assert property (p_start)
		else $error("motion start does not follow start bit");

	property p_reg_ack;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_access |=> terminal_status_byte_out[SB_REGACK]
		&& terminal_status_byte_out[REGNO_W-1:0] == $past(regno_q);
	endproperty
	a_reg_ack: assert property (p_reg_ack)
		else $error("register access not acknowledged");

	property p_auto_halt;
		@(posedge clk_in) disable iff (!rst_n_in)
		clk_en_in && proc_mode && is_track(operating_mode_in)
		|=> !automatic_halt_enable_out;
	endproperty
	a_auto_halt: assert property (p_auto_halt)
		else $error("auto stop enabled in position tracking");

endmodule

// ===== test/stp_ctrl_model.sv
// Fieldbus controller model driving the control byte and output word
`timescale 1ns/1ps
module stp_ctrl_model (
	input wire logic clk_in,
	input wire logic [stp_pkg::BYTE_W-1:0] status_in,
	input wire logic [stp_pkg::DATA_W-1:0] in_word_in,
	output logic [stp_pkg::BYTE_W-1:0] ctrl_out,
	output logic [stp_pkg::DATA_W-1:0] out_word_out
);
	import stp_pkg::*;

	// Idle image at time zero
	initial begin
		ctrl_out = 8'h00;
		out_word_out = 16'h0000;
	end

	// ****
	// Process data commands
	// ****
	// Velocity word never touched here, so start may be set freely
	task automatic pd(input logic [6:0] cmd);
		@(posedge clk_in);
		ctrl_out <= {1'b0, cmd};
	endtask

	// ****
	// Register access
	// ****
	// Holds the byte until the echo is sampled, then drops back to process
	// data and pauses so a repeated byte is not mistaken for a new echo
	task automatic reg_acc(input logic wr, input logic [5:0] regno,
		input logic [15:0] wdata, output logic ack, output logic [15:0] rd);
		logic [7:0] want;
		want = {1'b1, wr, regno};
		ack = 1'b0;
		@(posedge clk_in);
		ctrl_out <= want;
		// Unused word toggles so a stale value cannot pass
		out_word_out <= wr ? wdata : ~out_word_out;
		for (int i = 0; i < 8 && !ack; i++) begin
			@(posedge clk_in);
			ack = (status_in === want);
		end
		rd = in_word_in;
		ctrl_out <= 8'h00;
		repeat (2) @(posedge clk_in);
	endtask
endmodule

// ===== test/stp_status_byte_tb.sv
// Self-checking bench of the stepper control and status byte block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("MISMATCH %s exp %h got %h", nm, e, g); \
	end \
end
module stp_status_byte_tb;
	import stp_pkg::*;

	logic clk_in;
	logic rst_n_in;
	logic clk_en;
	logic [1:0] mode;
	logic err_ev;
	logic running;
	logic [7:0] temp;
	logic [2:0] angle;
	logic [15:0] pos;
	logic [7:0] cb;
	logic [7:0] sb;
	logic [15:0] dout;
	logic [15:0] din;
	logic men, rcur, ahalt, alaunch, start, ehalt, eclr;
	logic [15:0] rset, dset;
	int checks = 0;
	int failures = 0;

	// Clock of 5 ns
	always #2.5 clk_in = ~clk_in;

	stp_ctrl_model ctl (
		.clk_in(clk_in),
		.status_in(sb),
		.in_word_in(din),
		.ctrl_out(cb),
		.out_word_out(dout)
	);

	stp_status_byte uut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en),
		.motion_control_byte_in(cb),
		.output_data_word_in(dout),
		.operating_mode_in(mode),
		.error_event_in(err_ev),
		.motor_running_in(running),
		.die_temperature_in(temp),
		.load_angle_field_in(angle),
		.actual_position_in(pos),
		.terminal_status_byte_out(sb),
		.input_data_word_out(din),
		.motor_enable_out(men),
		.reduced_current_out(rcur),
		.automatic_halt_enable_out(ahalt),
		.automatic_launch_enable_out(alaunch),
		.motion_start_out(start),
		.emergency_halt_request_out(ehalt),
		.errors_cleared_out(eclr),
		.reduced_current_setting_out(rset),
		.emergency_deceleration_setting_out(dset)
	);

	// ****
	// Helpers
	// ****
	// Lets edge updates land before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// A missing echo ends the run, since later steps would be meaningless
	task automatic acc(input logic wr, input logic [5:0] rn,
		input logic [15:0] wd, input logic [15:0] exp);
		logic ak;
		logic [15:0] rd;
		ctl.reg_acc(wr, rn, wd, ak, rd);
		`CHK("ack", 1'b1, ak)
		if (ak !== 1'b1) results();
		if (!wr) `CHK("read", exp, rd)
	endtask

	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		logic p3;
		clk_in = 1'b0;
		rst_n_in = 1'b0;
		clk_en = 1'b1;
		mode = 2'h3;
		err_ev = 1'b0;
		running = 1'b0;
		temp = 8'h19;
		angle = 3'h0;
		pos = 16'hBEEF;
		repeat (16) @(posedge clk_in);
		`CHK("rst sb", 8'h00, sb)
		rst_n_in <= 1'b1;
		// Enable gives ready and position in the input word
		ctl.pd(7'h01);
		tick(2);
		`CHK("men", 1'b1, men)
		`CHK("sb ready", 8'h11, sb)
		`CHK("pos", 16'hBEEF, din)
		// Latched error, then cleared by a rising reset bit
		@(posedge clk_in);
		err_ev <= 1'b1;
		@(posedge clk_in);
		err_ev <= 1'b0;
		tick(2);
		`CHK("sb err", 8'h50, sb)
		ctl.pd(7'h41);
		tick(1);
		`CHK("eclr", 1'b1, eclr)
		tick(1);
		`CHK("eclr end", 1'b0, eclr)
		`CHK("sb clr", 8'h11, sb)
		// Error event in the clear cycle must keep the error set
		ctl.pd(7'h01);
		ctl.pd(7'h41);
		err_ev <= 1'b1;
		tick(1);
		`CHK("eclr both", 1'b1, eclr)
		`CHK("sb set wins", 8'h50, sb)
		@(posedge clk_in);
		err_ev <= 1'b0;
		// A fresh rising reset bit then clears it
		ctl.pd(7'h01);
		ctl.pd(7'h41);
		tick(2);
		`CHK("sb reclr", 8'h11, sb)
		// Every mode against command bits 0 to 5
		angle <= 3'h5;
		for (int md = 0; md < 4; md++) begin
			ctl.pd(7'h01);
			mode <= md[1:0];
			tick(2);
			ctl.pd(7'h3F);
			tick(1);
			p3 = (md == 3);
			`CHK("ehalt", p3, ehalt)
			`CHK("ahalt", (md != 2), ahalt)
			`CHK("alaunch", p3, alaunch)
			`CHK("start", p3, start)
			`CHK("rcur", 1'b1, rcur)
			`CHK("idle", !p3, sb[4])
			`CHK("angle", 3'h5, sb[3:1])
			tick(1);
			`CHK("ehalt end", 1'b0, ehalt)
		end
		// Register accesses, reset value first
		acc(1'b0, REG_REDCUR, 16'h0000, 16'h0000);
		acc(1'b1, REG_REDCUR, 16'h1234, 16'h0000);
		acc(1'b1, REG_EDECEL, 16'hA5C3, 16'h0000);
		acc(1'b1, REG_ANGLE_THR, 16'h0003, 16'h0000);
		acc(1'b0, REG_REDCUR, 16'h0000, 16'h1234);
		acc(1'b0, REG_EDECEL, 16'h0000, 16'hA5C3);
		`CHK("rset", 16'h1234, rset)
		`CHK("dset", 16'hA5C3, dset)
		// Warning by temperature and by load angle over threshold
		ctl.pd(7'h01);
		temp <= 8'h51;
		angle <= 3'h0;
		pos <= 16'h1357;
		tick(2);
		`CHK("warn t81", 1'b1, sb[5])
		`CHK("pos new", 16'h1357, din)
		@(posedge clk_in);
		temp <= 8'h50;
		angle <= 3'h4;
		tick(2);
		`CHK("warn a4", 1'b1, sb[5])
		@(posedge clk_in);
		angle <= 3'h3;
		running <= 1'b1;
		tick(2);
		`CHK("warn a3", 1'b0, sb[5])
		`CHK("idle run", 1'b0, sb[4])
		// Frozen clock enable holds the motor enable output
		@(posedge clk_in);
		clk_en <= 1'b0;
		ctl.pd(7'h00);
		tick(3);
		`CHK("frozen", 1'b1, men)
		@(posedge clk_in);
		clk_en <= 1'b1;
		tick(2);
		`CHK("men off", 1'b0, men)
		results();
	end
endmodule
